// [design/chip_config_defines.svh]
// offsets, field masks, reset values of the configuration bank
// assumes a 32-bit apb data path and byte addresses on paddr
`ifndef CHIP_CONFIG_DEFINES_SVH
`define CHIP_CONFIG_DEFINES_SVH
`define ADDR_W_DEF 12
`define OFF_WORD_ONE 12'h004
`define OFF_WORD_TWO 12'h008
`define OFF_GROUP_ZERO 12'h010
`define OFF_GROUP_ONE 12'h014
`define WORD_ONE_WMASK 32'h7003_df00
`define WORD_ONE_RMASK 32'h77ff_ffff
`define WORD_TWO_WMASK 32'h0000_3ffc
`define WORD_TWO_RMASK 32'h00f0_3ffc
`define WORD_ONE_RST 32'h0000_1000
`define WORD_TWO_RST 32'h0000_0000
`define GROUP_ZERO_W 16
`define GROUP_ZERO_MASK 16'hffbf
`define GROUP_ZERO_RST 16'h0000
`define GROUP_ONE_W 4
`define GROUP_ONE_MASK 4'hb
`define GROUP_ONE_RST 4'h0
`define SLOT_SELF 6
`define SLOT_CONFIG_CTRL 2
`define SLOT_EXT_AXI 0
`define SLOT_ENTIRE_APB 3
`define PROT_NONSECURE 1
`endif

// [design/chip_config_pkg.sv]
// types shared by the configuration bank and its surroundings
// assumes the defines header supplies every numeric constant
package chip_config_pkg;
    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [2:0] prot;
        logic [11:0] addr;
        logic [31:0] wdata;
    } apb_req_type;
    typedef struct packed {
        logic [31:0] rdata;
        logic ready;
        logic slverr;
    } apb_rsp_type;
    typedef struct packed {
        logic secure_noninvasive_debug_en;
        logic secure_invasive_debug_en;
        logic noninvasive_debug_en;
        logic invasive_debug_en;
    } debug_en_type;
    typedef struct packed {
        logic rsvd_31;
        logic [2:0] boot_remap_select;
        logic rsvd_27;
        logic [3:0] cluster_number;
        logic outer_cache_big_endian;
        logic [3:0] core_endian_config;
        logic [3:0] sysctl_coproc_write_lock;
        logic static_mem_space_guard_enable;
        logic outer_cache_enable;
        debug_en_type debug_en;
        logic rsvd_7;
        logic [3:0] memclk_pll_out_c_div;
        logic [2:0] memclk_pll_out_b_div_hi;
    } word_one_type;
    typedef struct packed {
        logic [7:0] rsvd_hi;
        logic [3:0] trace_clk_delay;
        logic [5:0] rsvd_mid;
        logic [3:0] compact_isa_exception_boot;
        logic [3:0] fast_irq_nonmaskable;
        logic [3:0] high_vector_select;
        logic [1:0] rsvd_lo;
    } word_two_type;
endpackage

// [design/chip_config_regs.sv]
// configuration bank of the system config controller with port protection
// assumes an apb master on clk; pprot[1] high marks a non-secure access
`timescale 1ns/10ps
`include "chip_config_defines.svh"

//Function
//- only flagged fields accept apb writes
//- other bits read-only, writes leave them
//- reserved bits read zero, software preserves
//- word one [26:23] drives cluster number
//- bit 22 drives outer cache endianness
//- bits [21:18] drive core endianness bus
//- bits [17:14] drive coprocessor write lock
//- bit 13 enables static memory guard
//- bit 12 low bypasses outer cache
//- bits 11..8 drive four debug enables
//- bits [6:3] drive pll out-c divider
//- bits [2:0] drive out-b divider [3:1]
//- word two [23:20] drives trace delay
//- word two drives three per-core buses
//- protection low means secure-only port
//- protection high admits both kinds
//- controller own slot reads zero, ignores
//- group zero bit 2 gates this controller
//- group one bits 0,3 gate axi, apb
//- out-b divider bit 0 from earlier register
module chip_config_regs #(
    parameter int ADDR_W = `ADDR_W_DEF
) (
    input wire logic clk,
    input wire logic nrst,
    input wire chip_config_pkg::apb_req_type apb_req,
    output chip_config_pkg::apb_rsp_type apb_rsp,
    input wire logic memclk_pb_div_lsb,
    output logic [2:0] boot_remap_select,
    output logic [3:0] cluster_number,
    output logic outer_cache_big_endian,
    output logic [3:0] core_endian_config,
    output logic [3:0] sysctl_coproc_write_lock,
    output logic static_mem_space_guard_enable,
    output logic outer_cache_bypass,
    output chip_config_pkg::debug_en_type debug_en,
    output logic [3:0] memclk_pll_out_c_div,
    output logic [3:0] memclk_pll_out_b_div,
    output logic [3:0] trace_clk_delay,
    output logic [3:0] compact_isa_exception_boot,
    output logic [3:0] fast_irq_nonmaskable,
    output logic [3:0] high_vector_select,
    output logic [`GROUP_ZERO_W-1:0] port_protect_group_zero,
    output logic [`GROUP_ONE_W-1:0] port_protect_group_one
);
    import chip_config_pkg::*;

    generate
        if (ADDR_W != 12) begin : g_bad_addr
            $error("chip_config_regs: ADDR_W must match the 12-bit request");
        end
    endgenerate

    logic [31:0] word_one_q;
    logic [31:0] word_two_q;
    logic [`GROUP_ZERO_W-1:0] group_zero_q;
    logic [`GROUP_ONE_W-1:0] group_one_q;
    logic pb_lsb_q;
    logic [31:0] rdata_q;
    logic nonsecure;
    logic allowed;
    logic setup;
    logic access;
    logic wr_ok;
    logic hit_one;
    logic hit_two;
    logic hit_g0;
    logic hit_g1;
    logic mapped;
    logic [31:0] rd_value;
    word_one_type one_view;
    word_two_type two_view;

    assign setup = apb_req.sel && !apb_req.enable;
    assign access = apb_req.sel && apb_req.enable;
    assign nonsecure = apb_req.prot[`PROT_NONSECURE];
    assign hit_one = apb_req.addr == `OFF_WORD_ONE;
    assign hit_two = apb_req.addr == `OFF_WORD_TWO;
    assign hit_g0 = apb_req.addr == `OFF_GROUP_ZERO;
    assign hit_g1 = apb_req.addr == `OFF_GROUP_ONE;
    assign mapped = hit_one || hit_two || hit_g0 || hit_g1;

    // non-secure gating
    // the protection registers themselves never open to non-secure masters
    always_comb begin
        allowed = 1'b1;
        if (nonsecure) begin
            allowed = group_zero_q[`SLOT_CONFIG_CTRL] && group_one_q[`SLOT_ENTIRE_APB]
                && !(hit_g0 || hit_g1);
        end
    end

    assign wr_ok = access && apb_req.write && allowed;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            word_one_q <= `WORD_ONE_RST;
        end else if (wr_ok && hit_one) begin
            word_one_q <= (word_one_q & ~`WORD_ONE_WMASK)
                | (apb_req.wdata & `WORD_ONE_WMASK);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            word_two_q <= `WORD_TWO_RST;
        end else if (wr_ok && hit_two) begin
            word_two_q <= (word_two_q & ~`WORD_TWO_WMASK)
                | (apb_req.wdata & `WORD_TWO_WMASK);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            group_zero_q <= `GROUP_ZERO_RST;
        end else if (wr_ok && hit_g0) begin
            group_zero_q <= apb_req.wdata[`GROUP_ZERO_W-1:0] & `GROUP_ZERO_MASK;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            group_one_q <= `GROUP_ONE_RST;
        end else if (wr_ok && hit_g1) begin
            group_one_q <= apb_req.wdata[`GROUP_ONE_W-1:0] & `GROUP_ONE_MASK;
        end
    end

    // divider lsb captured
    // the lsb lives in another register; it is reflopped so all bits move together
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pb_lsb_q <= 1'b0;
        end else begin
            pb_lsb_q <= memclk_pb_div_lsb;
        end
    end

    always_comb begin
        rd_value = 32'h0000_0000;
        if (allowed) begin
            if (hit_one) begin
                rd_value = word_one_q & `WORD_ONE_RMASK;
            end else if (hit_two) begin
                rd_value = word_two_q & `WORD_TWO_RMASK;
            end else if (hit_g0) begin
                rd_value = {16'h0000, group_zero_q};
            end else if (hit_g1) begin
                rd_value = {28'h000_0000, group_one_q};
            end
        end
    end

    // read data is taken in the setup phase so it leaves a flop
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 32'h0000_0000;
        end else if (setup) begin
            rdata_q <= rd_value;
        end
    end

    assign apb_rsp.rdata = rdata_q;
    assign apb_rsp.ready = 1'b1;
    assign apb_rsp.slverr = access && (!allowed || !mapped);

    assign one_view = word_one_type'(word_one_q);
    assign two_view = word_two_type'(word_two_q);

    assign boot_remap_select = one_view.boot_remap_select;
    assign cluster_number = one_view.cluster_number;
    assign outer_cache_big_endian = one_view.outer_cache_big_endian;
    assign core_endian_config = one_view.core_endian_config;
    assign sysctl_coproc_write_lock = one_view.sysctl_coproc_write_lock;
    assign static_mem_space_guard_enable = one_view.static_mem_space_guard_enable;
    assign outer_cache_bypass = !one_view.outer_cache_enable;
    assign debug_en = one_view.debug_en;
    assign memclk_pll_out_c_div = one_view.memclk_pll_out_c_div;
    assign memclk_pll_out_b_div = {one_view.memclk_pll_out_b_div_hi, pb_lsb_q};
    assign trace_clk_delay = two_view.trace_clk_delay;
    assign compact_isa_exception_boot = two_view.compact_isa_exception_boot;
    assign fast_irq_nonmaskable = two_view.fast_irq_nonmaskable;
    assign high_vector_select = two_view.high_vector_select;
    assign port_protect_group_zero = group_zero_q;
    assign port_protect_group_one = group_one_q;

    a_wr_one_field: assert property (@(posedge clk) disable iff (!nrst)
        (wr_ok && hit_one) |=> ((word_one_q & `WORD_ONE_WMASK)
            == ($past(apb_req.wdata) & `WORD_ONE_WMASK)))
        else $error("word one writable field missed the write");

    a_ro_bits_hold: assert property (@(posedge clk) disable iff (!nrst)
        ($stable(word_one_q & ~`WORD_ONE_WMASK))
        && ($stable(word_two_q & ~`WORD_TWO_WMASK)))
        else $error("read-only bit changed");

    a_rsvd_read_zero: assert property (@(posedge clk) disable iff (!nrst)
        (setup && hit_two) |=> (rdata_q[31:24] == 8'h00 && rdata_q[19:14] == 6'h00
            && rdata_q[1:0] == 2'h0))
        else $error("reserved bits of word two read nonzero");

    a_cache_bypass: assert property (@(posedge clk) disable iff (!nrst)
        (wr_ok && hit_one) |=> (outer_cache_bypass == !$past(apb_req.wdata[12])))
        else $error("cache bypass does not follow written bit");

    a_pb_divider: assert property (@(posedge clk) disable iff (!nrst)
        memclk_pll_out_b_div == {word_one_q[2:0], $past(memclk_pb_div_lsb)})
        else $error("out-b divider assembled wrongly");

    a_self_slot: assert property (@(posedge clk) disable iff (!nrst)
        (wr_ok && hit_g0) |=> (port_protect_group_zero[`SLOT_SELF] == 1'b0)
            && (port_protect_group_zero[5:0] == $past(apb_req.wdata[5:0])))
        else $error("protection own slot accepted a write");

    a_nsec_refused: assert property (@(posedge clk) disable iff (!nrst)
        (access && nonsecure && !group_zero_q[`SLOT_CONFIG_CTRL])
            |-> (apb_rsp.slverr && !wr_ok))
        else $error("non-secure access not refused");

    a_refused_rdata: assert property (@(posedge clk) disable iff (!nrst)
        (setup && !allowed) |=> (rdata_q == 32'h0000_0000))
        else $error("refused read leaked data");

    a_apb_gate: assert property (@(posedge clk) disable iff (!nrst)
        (access && apb_req.write && nonsecure && !group_one_q[`SLOT_ENTIRE_APB])
            |=> $stable(word_two_q))
        else $error("write passed a closed apb gate");

    a_out_latency: assert property (@(posedge clk) disable iff (!nrst)
        (wr_ok && hit_two) |=> (high_vector_select == $past(apb_req.wdata[5:2]))
            ##1 ($stable(high_vector_select) || $past(wr_ok && hit_two)))
        else $error("high vector output late or wrong");

    a_remap_write: assert property (@(posedge clk) disable iff (!nrst)
        (wr_ok && hit_one) |=> (boot_remap_select == $past(apb_req.wdata[30:28])))
        else $error("remap bus missed the write");

    a_cluster_map: assert property (@(posedge clk) disable iff (!nrst)
        cluster_number == word_one_q[26:23])
        else $error("cluster number off its field");

    a_cache_endian: assert property (@(posedge clk) disable iff (!nrst)
        outer_cache_big_endian == word_one_q[22])
        else $error("cache endianness off its bit");

    a_core_endian: assert property (@(posedge clk) disable iff (!nrst)
        core_endian_config == word_one_q[21:18])
        else $error("core endianness off its field");

    a_coproc_lock: assert property (@(posedge clk) disable iff (!nrst)
        sysctl_coproc_write_lock == word_one_q[17:14])
        else $error("coprocessor lock off its field");

    a_guard_enable: assert property (@(posedge clk) disable iff (!nrst)
        static_mem_space_guard_enable == word_one_q[13])
        else $error("memory guard enable off its bit");

    a_debug_enables: assert property (@(posedge clk) disable iff (!nrst)
        debug_en.secure_noninvasive_debug_en == word_one_q[11]
            && debug_en.secure_invasive_debug_en == word_one_q[10]
            && debug_en.noninvasive_debug_en == word_one_q[9]
            && debug_en.invasive_debug_en == word_one_q[8])
        else $error("debug enables out of order");

    a_out_c_div: assert property (@(posedge clk) disable iff (!nrst)
        memclk_pll_out_c_div == word_one_q[6:3])
        else $error("out-c divider off its field");

    a_trace_delay: assert property (@(posedge clk) disable iff (!nrst)
        trace_clk_delay == word_two_q[23:20])
        else $error("trace delay off its field");

    a_isa_boot: assert property (@(posedge clk) disable iff (!nrst)
        compact_isa_exception_boot == word_two_q[13:10])
        else $error("exception boot bus off its field");

    a_fiq_nmi: assert property (@(posedge clk) disable iff (!nrst)
        fast_irq_nonmaskable == word_two_q[9:6])
        else $error("fast irq bus off its field");

    a_vector_lsb: assert property (@(posedge clk) disable iff (!nrst)
        (wr_ok && hit_two) |=> (word_two_q[2] == $past(apb_req.wdata[2])))
        else $error("word two bit 2 missed the write");

    a_group_one_write: assert property (@(posedge clk) disable iff (!nrst)
        (wr_ok && hit_g1) |=> (port_protect_group_one == ($past(apb_req.wdata[3:0]) & `GROUP_ONE_MASK)))
        else $error("protection group one missed the write");

    c_write_one: cover property (@(posedge clk) disable iff (!nrst)
        wr_ok && hit_one ##[1:3] access && !apb_req.write && hit_one);
    c_nsec_open: cover property (@(posedge clk) disable iff (!nrst)
        access && nonsecure && allowed && hit_two);
    c_refused: cover property (@(posedge clk) disable iff (!nrst)
        access && apb_rsp.slverr);
    c_gate_open: cover property (@(posedge clk) disable iff (!nrst)
        $rose(group_zero_q[`SLOT_CONFIG_CTRL]));
endmodule // chip_config_regs

// [tb/chip_config_regs_and_port_protection_test.sv]
// self-checking bench for the configuration bank and port protection
// assumes zero-wait apb and offsets from the defines header
`timescale 1ns/10ps
`include "chip_config_defines.svh"
module chip_config_regs_and_port_protection_test;
    import chip_config_pkg::*;
    logic clk, nrst, set_lsb, lsb, be, guard, byp, er;
    apb_req_type req;
    apb_rsp_type rsp;
    debug_en_type dbg;
    logic [2:0] remap;
    logic [3:0] cl, ce, lock, cdiv, bdiv, trace, cib, fin, hvs;
    logic [`GROUP_ZERO_W-1:0] g0;
    logic [`GROUP_ONE_W-1:0] g1;
    logic [31:0] rd, w1o, w2o;
    int err_count, total_checks;
    assign w1o = {2'b0, remap, cl, be, ce, lock, guard, byp, dbg, cdiv, bdiv};
    assign w2o = {16'h0, trace, cib, fin, hvs};
    prior_config_model partner (.clk(clk), .nrst(nrst), .set_lsb(set_lsb),
        .memclk_pb_div_lsb(lsb));
    chip_config_regs uut (.clk(clk), .nrst(nrst), .apb_req(req), .apb_rsp(rsp),
        .memclk_pb_div_lsb(lsb), .boot_remap_select(remap), .cluster_number(cl),
        .outer_cache_big_endian(be), .core_endian_config(ce), .sysctl_coproc_write_lock(lock),
        .static_mem_space_guard_enable(guard), .outer_cache_bypass(byp), .debug_en(dbg),
        .memclk_pll_out_c_div(cdiv), .memclk_pll_out_b_div(bdiv), .trace_clk_delay(trace),
        .compact_isa_exception_boot(cib), .fast_irq_nonmaskable(fin),
        .high_vector_select(hvs), .port_protect_group_zero(g0), .port_protect_group_one(g1));
    task automatic report_and_stop();
        if (err_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer; request held until the edge that samples ready
    task automatic acc(input logic w, input logic ns, input logic [11:0] a,
            input logic [31:0] d, input logic [31:0] exp_rd, input logic exp_err);
        int n;
        @(negedge clk);
        req = '{sel: 1'b1, enable: 1'b0, write: w, prot: {1'b0, ns, 1'b0}, addr: a, wdata: d};
        @(negedge clk);
        req.enable = 1'b1;
        #2;
        for (n = 0; rsp.ready !== 1'b1; n++) begin
            if (n == 16) begin
                err_count++;
                report_and_stop();
            end
            @(posedge clk);
            #2;
        end
        rd = rsp.rdata;
        er = rsp.slverr;
        @(posedge clk);
        @(negedge clk);
        req.sel = 1'b0;
        req.enable = 1'b0;
        chk({31'b0, er}, {31'b0, exp_err});
        if (!w) begin
            chk(rd, exp_rd);
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        nrst = 1'b0;
        set_lsb = 1'b0;
        req = '0;
        err_count = 0;
        total_checks = 0;
        repeat (2) @(posedge clk);
        @(negedge clk) nrst = 1'b1;
        acc(0, 0, `OFF_WORD_ONE, 0, 32'h0000_1000, 0);
        acc(0, 0, `OFF_WORD_TWO, 0, 32'h0000_0000, 0);
        acc(0, 0, `OFF_GROUP_ZERO, 0, 32'h0000_0000, 0);
        acc(0, 0, `OFF_GROUP_ONE, 0, 32'h0000_0000, 0);
        chk(w1o, 32'h0000_0000);
        acc(1, 0, `OFF_WORD_ONE, 32'hffff_ffff, 0, 0);
        acc(0, 0, `OFF_WORD_ONE, 0, 32'h7003_df00, 0);
        chk(w1o, 32'h3803_cf00);
        acc(1, 0, `OFF_WORD_ONE, 32'h0000_0000, 0, 0);
        chk(w1o, 32'h0000_1000);
        acc(1, 0, `OFF_WORD_TWO, 32'hffff_ffff, 0, 0);
        acc(0, 0, `OFF_WORD_TWO, 0, 32'h0000_3ffc, 0);
        chk(w2o, 32'h0000_0fff);
        acc(1, 0, `OFF_WORD_TWO, 32'h0000_0004, 0, 0);
        chk(w2o, 32'h0000_0001);
        @(negedge clk) set_lsb = 1'b1;
        repeat (3) @(negedge clk);
        chk(w1o, 32'h0000_1001);
        acc(0, 0, 12'h00c, 0, 32'h0, 1);
        acc(0, 1, `OFF_WORD_ONE, 0, 32'h0, 1);
        acc(1, 0, `OFF_GROUP_ZERO, 32'h0000_ffff, 0, 0);
        acc(0, 0, `OFF_GROUP_ZERO, 0, 32'h0000_ffbf, 0);
        chk({16'h0, g0}, 32'h0000_ffbf);
        acc(1, 0, `OFF_GROUP_ONE, 32'h0000_000f, 0, 0);
        acc(0, 0, `OFF_GROUP_ONE, 0, 32'h0000_000b, 0);
        chk({28'h0, g1}, 32'h0000_000b);
        acc(1, 1, `OFF_WORD_ONE, 32'hffff_ffff, 0, 0);
        acc(0, 1, `OFF_WORD_ONE, 0, 32'h7003_df00, 0);
        acc(0, 1, `OFF_WORD_TWO, 0, 32'h0000_0004, 0);
        acc(1, 1, `OFF_GROUP_ZERO, 32'h0, 0, 1);
        acc(0, 0, `OFF_GROUP_ZERO, 0, 32'h0000_ffbf, 0);
        acc(1, 0, `OFF_GROUP_ONE, 32'h0000_0007, 0, 0);
        acc(0, 1, `OFF_WORD_TWO, 0, 32'h0, 1);
        acc(1, 1, `OFF_WORD_TWO, 32'h0000_3ffc, 0, 1);
        acc(0, 0, `OFF_WORD_TWO, 0, 32'h0000_0004, 0);
        chk(w2o, 32'h0000_0001);
        report_and_stop();
    end
endmodule // chip_config_regs_and_port_protection_test

// [tb/prior_config_model.sv]
// model of the preceding configuration register, bit 31 only
// assumes the bench sets the bit value; held in a flop like the real register
`timescale 1ns/10ps
module prior_config_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic set_lsb,
    output logic memclk_pb_div_lsb
);
    // source of out-b divider bit 0
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            memclk_pb_div_lsb <= 1'b0;
        end else begin
            memclk_pb_div_lsb <= set_lsb;
        end
    end
endmodule // prior_config_model
